/* rtl/vqas_pkg.sv */
// constants and types for the video quantize, accumulate and serialize block
package vqas_pkg;

   // ==========================================================
   // geometry
   localparam int CHANNELS = 56;
   localparam int SENSED = 54;
   localparam int FRAME_LEN = 60;
   localparam logic [5:0] FRAME_LAST = 6'h3B;
   localparam logic [5:0] COUNT_MIN = 6'h01;
   localparam logic [5:0] COUNT_MAX = 6'h3B;
   localparam logic [5:0] COUNT_RESET = 6'h1E;
   localparam logic [8:0] HANDPRINT_OFFSET = 9'h036;
   localparam int SHIFT_DIV_DEFAULT = 4;

   // ==========================================================
   // register byte offsets
   localparam logic [5:0] OFS_CTRL = 6'h00;
   localparam logic [5:0] OFS_THRESH = 6'h04;
   localparam logic [5:0] OFS_COUNT = 6'h08;
   localparam logic [5:0] OFS_SIM_LO = 6'h0C;
   localparam logic [5:0] OFS_SIM_HI = 6'h10;
   localparam logic [5:0] OFS_LOAD_EN = 6'h14;
   localparam logic [5:0] OFS_STATUS = 6'h18;
   localparam logic [5:0] OFS_ACC_LO = 6'h1C;
   localparam logic [5:0] OFS_ACC_HI = 6'h20;

   // ==========================================================
   // field positions and reset values
   localparam int CTRL_HANDPRINT = 0;
   localparam int CTRL_SIM_SEL = 1;
   localparam int LOAD_UPRIGHT = 0;
   localparam int LOAD_INVERT = 1;
   localparam int STATUS_SERIAL = 8;
   localparam logic [7:0] THRESH_RESET = 8'h80;
   localparam logic [55:0] WHITE = {56{1'b1}};

   // ==========================================================
   // carriers
   typedef logic [7:0] vqas_level_t;
   typedef vqas_level_t [SENSED-1:0] vqas_samples_t;

   typedef struct packed {
      logic handprint;
      logic simSel;
   } vqas_mode_t;

   typedef struct packed {
      logic upright;
      logic invert;
   } vqas_load_en_t;

endpackage

/* rtl/vqas_load_reg.sv */
// 56-stage load register: parallel load, serial unload from the top stage
`timescale 1ns/1ps
`default_nettype none
module vqas_load_reg
   import vqas_pkg::*;
#(
   parameter int WIDTH = CHANNELS
) (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // control
   input wire logic shiftEn,
   input wire logic loadEn,
   input wire logic [WIDTH-1:0] loadData,
   // data out
   output logic serialOut,
   output logic [WIDTH-1:0] stages
);

   // ==========================================================
   // shift toward stage 0 (top), zeros enter at the bottom
   always_ff @(posedge clk) begin
      if (!rstn) begin
         stages <= {WIDTH{1'b1}};
      end else if (shiftEn) begin
         if (loadEn) begin
            stages <= loadData;
         end else begin
            stages <= {1'b0, stages[WIDTH-1:1]};
         end
      end
   end

   assign serialOut = stages[0];

endmodule
`default_nettype wire

/* rtl/vqas_top.sv */
// video quantize, accumulate and serialize front end with Avalon-MM registers
//
// The Avalon-MM slave port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module vqas_top
   import vqas_pkg::*;
#(
   parameter int SHIFT_DIV = SHIFT_DIV_DEFAULT
) (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // sampled video levels, one per sensed channel
   input wire vqas_samples_t sampleLevel,
   // Avalon-MM slave
   input wire logic [5:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest,
   // serial column out
   output logic scrubData,
   output logic thickenData,
   output logic bitStrobe
);

   // ==========================================================
   // registers
   vqas_mode_t mode;
   vqas_load_en_t loadEnable;
   logic [7:0] threshold;
   logic [5:0] accCount;
   logic [55:0] simVideo;
   logic [55:0] acc;
   logic [5:0] frameCnt;
   logic [15:0] divCnt;
   logic shiftTick;
   logic [55:0] optVideo;
   logic [55:0] video;
   logic [55:0] next_acc;
   logic [55:0] loadData;
   logic [55:0] loadStages;
   logic [8:0] effThreshold;
   logic inWindow;
   logic frameEnd;
   logic doLoad;
   logic serialBit;
   logic busTake;

   function automatic logic [5:0] clampCount(input logic [5:0] c);
      if (c < COUNT_MIN) begin
         return COUNT_MIN;
      end else if (c > COUNT_MAX) begin
         return COUNT_MAX;
      end
      return c;
   endfunction

   // ==========================================================
   // shift clock enable
   always_ff @(posedge clk) begin
      if (!rstn) begin
         divCnt <= '0;
         shiftTick <= 1'b0;
      end else if (divCnt == 16'(SHIFT_DIV - 1)) begin
         divCnt <= '0;
         shiftTick <= 1'b1;
      end else begin
         divCnt <= divCnt + 16'h0001;
         shiftTick <= 1'b0;
      end
   end

   // ==========================================================
   // quantizer
   always_comb begin
      effThreshold = {1'b0, threshold};
      if (mode.handprint) begin
         effThreshold = effThreshold + HANDPRINT_OFFSET;
      end
      optVideo[0] = 1'b1;
      optVideo[CHANNELS-1] = 1'b1;
      for (int i = 0; i < SENSED; i++) begin
         // a level at or above the reference is light
         optVideo[i+1] = ({1'b0, sampleLevel[i]} >= effThreshold);
      end
   end

   assign video = mode.simSel ? simVideo : optVideo;

   // ==========================================================
   // accumulator and frame counter
   assign frameEnd = (frameCnt == FRAME_LAST);
   // window covers periods count..59, so a low count spans more periods
   assign inWindow = (frameCnt >= accCount);
   assign next_acc = inWindow ? (acc & video) : acc;

   always_ff @(posedge clk) begin
      if (!rstn) begin
         frameCnt <= '0;
      end else if (shiftTick) begin
         frameCnt <= frameEnd ? 6'h00 : frameCnt + 6'h01;
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         acc <= WHITE;
      end else if (shiftTick) begin
         acc <= frameEnd ? WHITE : next_acc;
      end
   end

   // ==========================================================
   // orientation gating
   always_comb begin
      loadData = next_acc;
      if (!loadEnable.upright && loadEnable.invert) begin
         for (int i = 0; i < SENSED; i++) begin
            loadData[i] = next_acc[SENSED-1-i];
         end
      end
   end

   assign doLoad = frameEnd && (loadEnable.upright || loadEnable.invert);

   vqas_load_reg #(
      .WIDTH(CHANNELS)
   ) u_load (
      .clk(clk),
      .rstn(rstn),
      .shiftEn(shiftTick),
      .loadEn(doLoad),
      .loadData(loadData),
      .serialOut(serialBit),
      .stages(loadStages)
   );

   // top stage is itself a flip-flop; both downstream stages see it
   assign scrubData = serialBit;
   assign thickenData = serialBit;

   always_ff @(posedge clk) begin
      if (!rstn) begin
         bitStrobe <= 1'b0;
      end else begin
         bitStrobe <= shiftTick;
      end
   end

   // ==========================================================
   // Avalon-MM slave: one wait cycle, then the access completes
   assign busTake = (read || write) && !waitrequest;

   always_ff @(posedge clk) begin
      if (!rstn) begin
         waitrequest <= 1'b1;
      end else begin
         waitrequest <= !((read || write) && waitrequest);
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         mode <= '0;
         threshold <= THRESH_RESET;
         accCount <= COUNT_RESET;
         simVideo <= WHITE;
         loadEnable <= '0;
      end else if (busTake && write) begin
         case (address)
            OFS_CTRL: begin
               mode.handprint <= writedata[CTRL_HANDPRINT];
               mode.simSel <= writedata[CTRL_SIM_SEL];
            end
            OFS_THRESH: begin
               threshold <= writedata[7:0];
            end
            OFS_COUNT: begin
               accCount <= clampCount(writedata[5:0]);
            end
            OFS_SIM_LO: begin
               simVideo[31:0] <= writedata;
            end
            OFS_SIM_HI: begin
               simVideo[55:32] <= writedata[23:0];
            end
            OFS_LOAD_EN: begin
               loadEnable.upright <= writedata[LOAD_UPRIGHT];
               loadEnable.invert <= writedata[LOAD_INVERT];
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         readdata <= '0;
      end else if ((read || write) && waitrequest) begin
         readdata <= '0;
         if (read) begin
            case (address)
               OFS_CTRL: begin
                  readdata[CTRL_HANDPRINT] <= mode.handprint;
                  readdata[CTRL_SIM_SEL] <= mode.simSel;
               end
               OFS_THRESH: begin
                  readdata[7:0] <= threshold;
               end
               OFS_COUNT: begin
                  readdata[5:0] <= accCount;
               end
               OFS_SIM_LO: begin
                  readdata <= simVideo[31:0];
               end
               OFS_SIM_HI: begin
                  readdata[23:0] <= simVideo[55:32];
               end
               OFS_LOAD_EN: begin
                  readdata[LOAD_UPRIGHT] <= loadEnable.upright;
                  readdata[LOAD_INVERT] <= loadEnable.invert;
               end
               OFS_STATUS: begin
                  readdata[5:0] <= frameCnt;
                  readdata[STATUS_SERIAL] <= serialBit;
               end
               OFS_ACC_LO: begin
                  readdata <= acc[31:0];
               end
               OFS_ACC_HI: begin
                  readdata[23:0] <= acc[55:32];
               end
               default: begin
                  readdata <= '0;
               end
            endcase
         end
      end
   end

endmodule
`default_nettype wire

/* verification/vqas_checker.sv */
// port assertions for vqas_top
`timescale 1ns/1ps
`default_nettype none
module vqas_checker
   import vqas_pkg::*;
#(
   parameter int SD = SHIFT_DIV_DEFAULT
) (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // register bus
   input wire logic [5:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] readdata,
   input wire logic waitrequest,
   // serial column
   input wire logic scrubData,
   input wire logic thickenData,
   input wire logic bitStrobe
);
   // ==========================================
   // properties
   localparam int SDM = SD - 1;
   default clocking dc @(posedge clk); endclocking
   default disable iff (!rstn);
   sequence s_req; (read || write) && waitrequest; endsequence
   sequence s_ans; !waitrequest ##1 waitrequest; endsequence
   property p_ack; s_req |=> s_ans; endproperty
   a_ack: assert property (p_ack) else $error("bus answer not one cycle");
   property p_cause; $fell(waitrequest) |-> $past(read || write); endproperty
   a_cause: assert property (p_cause) else $error("answer without request");
   property p_same; scrubData == thickenData; endproperty
   a_same: assert property (p_same) else $error("serial outputs differ");
   property p_per; bitStrobe |=> !bitStrobe ##SDM bitStrobe; endproperty
   a_per: assert property (p_per) else $error("shift period wrong");
   property p_hold; !bitStrobe |-> $stable(scrubData); endproperty
   a_hold: assert property (p_hold) else $error("serial bit moved off tick");
   property p_rd; waitrequest |-> $stable(readdata); endproperty
   a_rd: assert property (p_rd) else $error("read data moved while idle");
   property p_unmap; !waitrequest && read && address > OFS_ACC_HI |-> readdata == 32'h0; endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
   property p_rst;
      disable iff (1'b0) !rstn |=> waitrequest && scrubData && !bitStrobe;
   endproperty
   a_rst: assert property (p_rst) else $error("reset state wrong");
endmodule
bind vqas_top vqas_checker #(.SD(SHIFT_DIV)) i_chk (.clk(clk), .rstn(rstn), .address(address),
   .read(read), .write(write), .readdata(readdata), .waitrequest(waitrequest),
   .scrubData(scrubData), .thickenData(thickenData), .bitStrobe(bitStrobe));
`default_nettype wire

/* verification/vqas_sink.sv */
// downstream collector of the serial column
`timescale 1ns/1ps
`default_nettype none
module vqas_sink (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // serial in
   input wire logic strobe,
   input wire logic din,
   // collected column
   output logic [55:0] col,
   output logic [7:0] frames,
   output logic zeroBad
);
   // ==========================================
   // position in frame, stage 0 arrives at 59
   logic [5:0] pos;
   logic [54:0] part;
   always_ff @(posedge clk) begin
      if (!rstn) begin
         pos <= 6'h00;
         frames <= 8'h00;
         zeroBad <= 1'b0;
      end else if (strobe) begin
         pos <= (pos == 6'h3B) ? 6'h00 : pos + 6'h01;
         if (pos == 6'h3B) part[0] <= din;
         else if (pos < 6'h36) part[pos + 6'h01] <= din;
         else if (pos > 6'h36 && din) zeroBad <= 1'b1;
         if (pos == 6'h36) begin
            col <= {din, part};
            frames <= frames + 8'h01;
         end
      end
   end
endmodule
`default_nettype wire

/* verification/testbench.sv */
// self-checking bench for vqas_top
`timescale 1ns/1ps
`default_nettype none
module testbench import vqas_pkg::*;;
   // ==========================================
   // signals
   logic clk = 1'b0;
   logic rstn = 1'b0;
   vqas_samples_t lv = {SENSED{8'h80}};
   logic [5:0] address = 6'h00;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [31:0] writedata = 32'h0;
   logic [31:0] readdata;
   logic [31:0] q;
   logic waitrequest;
   logic scrubData;
   logic thickenData;
   logic bitStrobe;
   logic [55:0] col;
   logic [7:0] frames;
   logic zeroBad;
   int badCount = 0;
   int checksDone = 0;
   always #12.5 clk = ~clk;
   vqas_top #(.SHIFT_DIV(2)) i_dut (.clk(clk), .rstn(rstn), .sampleLevel(lv), .address(address),
      .read(read), .write(write), .writedata(writedata), .readdata(readdata),
      .waitrequest(waitrequest), .scrubData(scrubData), .thickenData(thickenData), .bitStrobe(bitStrobe));
   vqas_sink i_sink (.clk(clk), .rstn(rstn), .strobe(bitStrobe), .din(scrubData), .col(col),
      .frames(frames), .zeroBad(zeroBad));
   // ==========================================
   // helpers
   task automatic summarize;
      $display("checks %0d, mismatches %0d", checksDone, badCount);
      if (badCount == 0 && checksDone > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input logic [55:0] s, input logic [55:0] e, input string m);
      checksDone++;
      if (s !== e) begin
         badCount++;
         $display("wrong value at %0t: %s", $time, m);
      end
   endtask
   task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      address <= a;
      writedata <= d;
      write <= w;
      read <= !w;
      do begin
         @(posedge clk);
         n++;
      end while (waitrequest !== 1'b0 && n < 40);
      q = readdata;
      write <= 1'b0;
      read <= 1'b0;
      if (n >= 40) begin
         badCount++;
         summarize();
      end
   endtask
   task automatic rd(input logic [5:0] a, input logic [55:0] e, input string m);
      bus(1'b0, a, 32'h0);
      chk(56'(q), e, m);
   endtask
   task automatic cfg(input logic [1:0] c, input logic [7:0] t, input logic [5:0] n, input logic [1:0] l);
      bus(1'b1, OFS_CTRL, {30'h0, c});
      bus(1'b1, OFS_THRESH, {24'h0, t});
      bus(1'b1, OFS_COUNT, {26'h0, n});
      bus(1'b1, OFS_LOAD_EN, {30'h0, l});
   endtask
   task automatic cap(input logic [55:0] e, input string m);
      int n;
      logic [7:0] f;
      n = 0;
      f = frames;
      while (frames !== f + 8'h03 && n < 2000) begin
         @(posedge clk);
         n++;
      end
      if (n >= 2000) begin
         badCount++;
         summarize();
      end
      chk(col, e, m);
      chk({55'h0, thickenData}, {55'h0, scrubData}, "thicken feed");
      $display("test %s done", m);
   endtask
   function automatic logic [55:0] vid(input logic [8:0] t);
      logic [55:0] v;
      v = WHITE;
      for (int k = 0; k < SENSED; k++) v[k + 1] = {1'b0, lv[k]} >= t;
      return v;
   endfunction
   function automatic logic [55:0] flip(input logic [55:0] v);
      logic [55:0] r;
      r = v;
      for (int i = 0; i < SENSED; i++) r[i] = v[SENSED - 1 - i];
      return r;
   endfunction
   // ==========================================
   // scenarios
   task automatic t_regs;
      rd(OFS_COUNT, 56'h1E, "count reset");
      rd(OFS_THRESH, 56'h80, "threshold reset");
      rd(6'h3C, 56'h0, "unmapped read");
      bus(1'b1, OFS_COUNT, 32'h0);
      rd(OFS_COUNT, 56'h1, "count floor");
      bus(1'b1, OFS_COUNT, 32'h3F);
      rd(OFS_COUNT, 56'h3B, "count ceiling");
      $display("test registers done");
   endtask
   task automatic t_opt;
      lv[0] <= 8'h7F;
      lv[5] <= 8'h00;
      cfg(2'b00, 8'h80, 6'h01, 2'b01);
      cap(vid(9'h080), "optical upright");
   endtask
   task automatic t_inv;
      cfg(2'b00, 8'h80, 6'h01, 2'b10);
      cap(flip(vid(9'h080)), "inverted");
   endtask
   task automatic t_hand;
      lv[2] <= 8'hB6;
      cfg(2'b01, 8'h80, 6'h1E, 2'b01);
      cap(vid(9'h0B6), "handprint");
   endtask
   task automatic t_sim;
      bus(1'b1, OFS_SIM_LO, 32'h0F123487);
      bus(1'b1, OFS_SIM_HI, 32'h005AC3F0);
      cfg(2'b10, 8'h80, 6'h3B, 2'b01);
      rd(OFS_CTRL, 56'h2, "source select readback");
      rd(OFS_LOAD_EN, 56'h1, "load enable readback");
      cap(56'h5AC3F00F123487, "simulated");
   endtask
   task automatic t_off;
      cfg(2'b00, 8'h80, 6'h1E, 2'b00);
      cap(56'h0, "no load");
      chk({55'h0, zeroBad}, 56'h0, "zero fill");
   endtask
   initial begin
      repeat (8) @(posedge clk);
      rstn <= 1'b1;
      t_regs();
      t_opt();
      t_inv();
      t_hand();
      t_sim();
      t_off();
      summarize();
   end
endmodule
`default_nettype wire
